// ---- verilog/cfcr_pkg.sv ----
/*
  Shared constants and types for the charger flag and charge setting bank:
  register offsets, reset values, field positions and scaling figures.
  Assumes nothing of its surroundings; imported by every design file.
*/
package cfcr_pkg;
  // --------------------------------------------------------------
  // serial bus identity and register offsets
  // --------------------------------------------------------------
  // arbitrary target address, not tied to any product
  localparam logic [6:0] I2C_DEV_ADDR = 7'h35;
  localparam logic [7:0] OFS_FLAGS = 8'h02;
  localparam logic [7:0] OFS_VBAT = 8'h03;
  localparam logic [7:0] OFS_ICHG = 8'h04;
  localparam logic [7:0] OFS_CTRL0 = 8'h05;
  localparam logic [7:0] OFS_CTRL1 = 8'h06;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_VBAT = 8'h46;
  localparam logic [7:0] RST_ICHG = 8'h05;
  localparam logic [7:0] RST_CTRL0 = 8'h2C;
  localparam logic [7:0] RST_CTRL1 = 8'h56;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int FLG_TS = 7;
  localparam int FLG_ILIM = 6;
  localparam int FLG_SYSDPM = 5;
  localparam int FLG_INDPM = 4;
  localparam int FLG_THERM = 3;
  localparam int FLG_OVP = 2;
  localparam int FLG_UV = 1;
  localparam int FLG_OCP = 0;
  localparam int CHARGE_DISABLE_BIT = 7;
  localparam int PRECHG_BIT = 6;
  localparam int TERM_LSB = 4;
  localparam int INREG_LSB = 2;
  localparam int THERM_LSB = 0;
  localparam int OCP_LSB = 6;
  localparam int BUVLO_LSB = 3;
  localparam int MASK_CS_BIT = 2;
  localparam int MASK_ILIM_BIT = 1;
  localparam int MASK_DPM_BIT = 0;
  // --------------------------------------------------------------
  // scaling figures
  // --------------------------------------------------------------
  localparam logic [12:0] VBAT_BASE_MV = 13'hDAC;
  localparam logic [12:0] VBAT_STEP_MV = 13'h00A;
  localparam logic [12:0] VBAT_MAX_MV = 13'h122A;
  localparam logic [10:0] ICHG_OFS_MA = 11'h005;
  localparam logic [10:0] ICHG_KNEE_CODE = 11'h01F;
  localparam logic [10:0] ICHG_KNEE_MA = 11'h028;
  localparam logic [10:0] ICHG_STEP_MA = 11'h00A;
  localparam logic [10:0] ICHG_MAX_MA = 11'h3E8;
  localparam logic [11:0] BUVLO_TOP_MV = 12'hBB8;
  localparam logic [11:0] BUVLO_STEP_MV = 12'h0C8;
  localparam logic [2:0] BUVLO_FLAT_CODE = 3'h2;
  localparam logic [1:0] TERM_OFF = 2'h0;
  localparam logic [1:0] TERM_5PCT = 2'h1;
  localparam logic [1:0] TERM_10PCT = 2'h2;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    CS_IDLE = 2'h0, CS_CC = 2'h1, CS_CV = 2'h2, CS_DONE = 2'h3
  } cfcr_chg_state_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h3, S_PTR = 3'h2,
    S_WDAT = 3'h6, S_WACK = 3'h7, S_RDAT = 3'h5, S_RACK = 3'h4
  } cfcr_bus_st_t;
endpackage

// ---- verilog/cfcr_calc.sv ----
/*
  Turns the raw setting bytes into regulation targets in engineering units.
  Assumes the bytes come from flops on the same clock; all outputs are flops.
*/
`timescale 1ns/10ps
module cfcr_calc (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // setting bytes
  input wire logic [7:0] vbat_reg,
  input wire logic [7:0] ichg_reg,
  input wire logic [7:0] ctrl0_reg,
  input wire logic [7:0] ctrl1_reg,
  // targets
  output logic [12:0] vbat_mv,
  output logic [9:0] ichg_ma,
  output logic chg_en,
  output logic [10:0] term_x10,
  output logic [11:0] prechg_x10,
  output logic [11:0] uv_mv
);
  import cfcr_pkg::*;
  logic [12:0] vb_c;
  logic [10:0] ic_c;
  logic [10:0] tm_c;
  logic [11:0] uv_c;
  logic [2:0] ucode;

  always_comb
  begin
    vb_c = VBAT_BASE_MV + {6'h00, vbat_reg[6:0]} * VBAT_STEP_MV; // RQ8
    if (vb_c > VBAT_MAX_MV)
      vb_c = VBAT_MAX_MV; // RQ9
    if ({4'h0, ichg_reg[6:0]} < ICHG_KNEE_CODE)
      ic_c = {4'h0, ichg_reg[6:0]} + ICHG_OFS_MA; // RQ10
    else
      ic_c = ICHG_KNEE_MA + ({4'h0, ichg_reg[6:0]} - ICHG_KNEE_CODE) * ICHG_STEP_MA; // RQ11
    if (ic_c > ICHG_MAX_MA)
      ic_c = ICHG_MAX_MA; // RQ12
    // tenths of a milliamp keep the 5 percent step exact to half a count
    case (ctrl0_reg[TERM_LSB +: 2]) // RQ15
      TERM_OFF: tm_c = 11'h000;
      TERM_5PCT: tm_c = {1'b0, ic_c[10:1]};
      TERM_10PCT: tm_c = ic_c;
      default: tm_c = {ic_c[9:0], 1'b0};
    endcase
    ucode = ctrl1_reg[BUVLO_LSB +: 3];
    if (ucode <= BUVLO_FLAT_CODE)
      uv_c = BUVLO_TOP_MV; // RQ16
    else
      uv_c = BUVLO_TOP_MV - {9'h000, 3'(ucode - BUVLO_FLAT_CODE)} * BUVLO_STEP_MV;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      vbat_mv <= 13'h0000;
      ichg_ma <= 10'h000;
      chg_en <= 1'b0;
      term_x10 <= 11'h000;
      prechg_x10 <= 12'h000;
      uv_mv <= 12'h000;
    end
    else if (ce)
    begin
      vbat_mv <= vb_c;
      ichg_ma <= ic_c[9:0];
      chg_en <= !ichg_reg[CHARGE_DISABLE_BIT]; // RQ13
      term_x10 <= tm_c;
      prechg_x10 <= ctrl0_reg[PRECHG_BIT] ? {1'b0, tm_c} : {tm_c, 1'b0}; // RQ14
      uv_mv <= uv_c;
    end
  end

  a_vbat_code: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ8
    (VBAT_BASE_MV + {6'h00, vbat_reg[6:0]} * VBAT_STEP_MV <= VBAT_MAX_MV) |=>
    vbat_mv == VBAT_BASE_MV + {6'h00, $past(vbat_reg[6:0])} * VBAT_STEP_MV)
    else $error("battery target does not follow its code");
  a_vbat_cap: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ9
    vbat_mv <= VBAT_MAX_MV) else $error("battery target above ceiling");
  a_ichg_low: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ10
    ({4'h0, ichg_reg[6:0]} < ICHG_KNEE_CODE) |=>
    {1'b0, ichg_ma} == {4'h0, $past(ichg_reg[6:0])} + ICHG_OFS_MA)
    else $error("low charge current wrong");
  a_ichg_knee: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ11
    ({4'h0, ichg_reg[6:0]} == ICHG_KNEE_CODE) |=> {1'b0, ichg_ma} == ICHG_KNEE_MA)
    else $error("charge current at knee wrong");
  a_ichg_cap: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ12
    {1'b0, ichg_ma} <= ICHG_MAX_MA) else $error("charge current above ceiling");
  a_charge_disable: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ13
    1'b1 |=> chg_en == !$past(ichg_reg[CHARGE_DISABLE_BIT])) else $error("charge enable wrong");
  a_prechg_ratio: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ14
    1'b1 |=> prechg_x10 == ($past(ctrl0_reg[PRECHG_BIT]) ? {1'b0, term_x10} :
    {term_x10, 1'b0})) else $error("precharge ratio wrong");
  a_term_off: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ15
    (ctrl0_reg[TERM_LSB +: 2] == TERM_OFF) |=> term_x10 == 11'h000)
    else $error("termination not disabled");
  a_uv_flat: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ16
    (ctrl1_reg[BUVLO_LSB +: 3] <= BUVLO_FLAT_CODE) |=> uv_mv == BUVLO_TOP_MV)
    else $error("undervoltage threshold wrong");
endmodule

// ---- verilog/cfcr_regs.sv ----
/*
  Charger fault flags and charge setting registers behind a two-wire serial
  target port. Assumes the bus pins and the analog status levels are
  asynchronous to core_clk; the host does the open-drain pull-up.
*/
`timescale 1ns/10ps
// --------------------------------------------------------------
// Function
// [RQ1] thermistor fault latches flag bit 7
// [RQ2] input current limit latches bit 6
// [RQ3] system and input power regulation latch 5,4
// [RQ4] thermal regulation latches bit 3
// [RQ5] input overvoltage latches bit 2
// [RQ6] battery undervoltage latches bit 1
// [RQ7] battery overcurrent latches bit 0
// [RQ8] battery target is base plus code steps
// [RQ9] battery target capped at ceiling
// [RQ10] low codes give code plus offset current
// [RQ11] high codes step ten milliamps past knee
// [RQ12] charge current capped at one amp
// [RQ13] disable bit stops charging
// [RQ14] precharge is twice or equal termination
// [RQ15] termination off, five, ten, twenty percent
// [RQ16] undervoltage threshold flat then falling steps
// [RQ17] charge state change interrupts unless masked
// [RQ18] input limit interrupts unless masked
// [RQ19] one mask gates both regulation interrupts
// [RQ20] charge state codes, disabled reports done
// [RQ21] flag read returns then clears bits
// [RQ22] host keeps reserved bits zero, read-modify-write
// --------------------------------------------------------------
module cfcr_regs (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // analog status levels
  input wire logic thermistor_fault,
  input wire logic input_limit_active,
  input wire logic sys_power_regulation,
  input wire logic input_voltage_regulation,
  input wire logic thermal_regulation,
  input wire logic input_overvoltage,
  input wire logic battery_undervoltage,
  input wire logic battery_overcurrent,
  input wire logic [1:0] charge_state_in,
  // regulation targets
  output logic [12:0] battery_voltage_mv,
  output logic [9:0] charge_current_ma,
  output logic charge_enable,
  output logic [10:0] term_current_x10,
  output logic [11:0] precharge_current_x10,
  output logic [11:0] undervoltage_mv,
  output logic [1:0] input_regulation_level,
  output logic [1:0] thermal_threshold_select,
  output logic [1:0] discharge_limit_select,
  // status
  output cfcr_pkg::cfcr_chg_state_t charge_state_code,
  output logic status_irq
);
  import cfcr_pkg::*;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [11:0] pin_raw;
  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic [7:0] ev_s;
  logic [7:0] ev_d_r;

  assign pin_raw = {scl_i, sda_i, charge_state_in, thermistor_fault,
    input_limit_active, sys_power_regulation, input_voltage_regulation,
    thermal_regulation, input_overvoltage, battery_undervoltage,
    battery_overcurrent};
  assign scl_s = pin_s2_r[11];
  assign sda_s = pin_s2_r[10];
  assign ev_s = pin_s2_r[7:0];

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 12'hC00;
      pin_s2_r <= 12'hC00;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      ev_d_r <= 8'h00;
    end
    else if (ce)
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      ev_d_r <= ev_s;
    end
  end

  // --------------------------------------------------------------
  // bus framing
  // --------------------------------------------------------------
  cfcr_bus_st_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic nack_r;
  logic [7:0] ptr_r;
  logic [7:0] rd_byte;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;
  logic byte_w;
  logic ptr_w;
  logic wr_w;
  logic ld_w;

  assign start_w = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_w = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign rise_w = scl_s && !scl_d_r;
  assign fall_w = !scl_s && scl_d_r;
  assign byte_w = (cnt_r == 4'h8);
  assign ptr_w = fall_w && byte_w && (st_r == S_PTR);
  assign wr_w = fall_w && byte_w && (st_r == S_WDAT);
  assign ld_w = fall_w && (((st_r == S_AACK) && sh_r[0]) ||
    ((st_r == S_RACK) && !nack_r));

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      nack_r <= 1'b0;
    end
    else if (ce)
    begin
      if (start_w)
      begin
        st_r <= S_ADDR;
        cnt_r <= 4'h0;
      end
      else if (stop_w)
        st_r <= S_IDLE;
      else
        case (st_r)
          S_ADDR, S_PTR, S_WDAT:
            if (rise_w)
            begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end
            else if (fall_w && byte_w)
            begin
              cnt_r <= 4'h0;
              if (st_r != S_ADDR)
                st_r <= S_WACK;
              else if (sh_r[7:1] == I2C_DEV_ADDR)
                st_r <= S_AACK;
              else
                st_r <= S_IDLE;
            end
          S_AACK:
            if (fall_w)
            begin
              if (sh_r[0])
              begin
                st_r <= S_RDAT;
                sh_r <= rd_byte;
              end
              else
                st_r <= S_PTR;
            end
          S_WACK:
            if (fall_w)
              st_r <= S_WDAT;
          S_RDAT:
            if (fall_w)
            begin
              sh_r <= {sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7)
              begin
                st_r <= S_RACK;
                cnt_r <= 4'h0;
              end
            end
          S_RACK:
            if (rise_w)
              nack_r <= sda_s;
            else if (fall_w)
            begin
              if (nack_r)
                st_r <= S_IDLE;
              else
              begin
                st_r <= S_RDAT;
                sh_r <= rd_byte;
              end
            end
          default:
            st_r <= S_IDLE;
        endcase
    end
  end

  // pointer auto-increments after each data byte written or loaded so bursts walk the bank
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ptr_r <= 8'h00;
    else if (ce)
    begin
      if (ptr_w)
        ptr_r <= sh_r;
      else if (wr_w || ld_w)
        ptr_r <= ptr_r + 8'h01;
    end
  end

  // open drain: only ever pull low, released two core cycles after the synchronised scl falls
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (ce)
    begin
      sda_o <= 1'b0;
      sda_oe <= (st_r == S_AACK) || (st_r == S_WACK) ||
        ((st_r == S_RDAT) && !sh_r[7]);
    end
  end

  // --------------------------------------------------------------
  // register bank
  // --------------------------------------------------------------
  logic [7:0] flags_r;
  logic [7:0] vbat_r;
  logic [7:0] ichg_r;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [7:0] flag_clr;

  // reserved bits are stored as written; unmapped writes are dropped
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      vbat_r <= RST_VBAT;
      ichg_r <= RST_ICHG;
      ctrl0_r <= RST_CTRL0;
      ctrl1_r <= RST_CTRL1;
    end
    else if (ce && wr_w)
    begin
      case (ptr_r)
        OFS_VBAT: vbat_r <= sh_r;
        OFS_ICHG: ichg_r <= sh_r;
        OFS_CTRL0: ctrl0_r <= sh_r;
        OFS_CTRL1: ctrl1_r <= sh_r;
        default: vbat_r <= vbat_r;
      endcase
    end
  end

  always_comb
  begin
    case (ptr_r)
      OFS_FLAGS: rd_byte = flags_r;
      OFS_VBAT: rd_byte = vbat_r;
      OFS_ICHG: rd_byte = ichg_r;
      OFS_CTRL0: rd_byte = ctrl0_r;
      OFS_CTRL1: rd_byte = ctrl1_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // clear on load into the shifter; an event in that cycle still sets
  assign flag_clr = (ld_w && (ptr_r == OFS_FLAGS)) ? 8'hFF : 8'h00; // RQ21

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      flags_r <= RST_FLAGS;
    else if (ce)
      flags_r <= (flags_r & ~flag_clr) | ev_s; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
  end

  // --------------------------------------------------------------
  // charge state and interrupt
  // --------------------------------------------------------------
  cfcr_chg_state_t cs_eff;
  logic irq_nxt;

  // host disable overrides what the analog side reports
  assign cs_eff = ichg_r[CHARGE_DISABLE_BIT] ? CS_DONE : cfcr_chg_state_t'(pin_s2_r[9:8]); // RQ20

  always_comb
  begin
    irq_nxt = (cs_eff != charge_state_code) && !ctrl1_r[MASK_CS_BIT]; // RQ17
    if (ev_s[FLG_ILIM] && !ev_d_r[FLG_ILIM] && !ctrl1_r[MASK_ILIM_BIT]) // RQ18
      irq_nxt = 1'b1;
    if ((|(ev_s[FLG_SYSDPM:FLG_INDPM] & ~ev_d_r[FLG_SYSDPM:FLG_INDPM])) &&
      !ctrl1_r[MASK_DPM_BIT]) // RQ19
      irq_nxt = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      charge_state_code <= CS_IDLE;
      status_irq <= 1'b0;
    end
    else if (ce)
    begin
      charge_state_code <= cs_eff;
      status_irq <= irq_nxt;
    end
  end

  // raw field outputs come straight from the setting flops
  assign input_regulation_level = ctrl0_r[INREG_LSB +: 2];
  assign thermal_threshold_select = ctrl0_r[THERM_LSB +: 2];
  assign discharge_limit_select = ctrl1_r[OCP_LSB +: 2];

  cfcr_calc u_calc (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .vbat_reg(vbat_r),
    .ichg_reg(ichg_r),
    .ctrl0_reg(ctrl0_r),
    .ctrl1_reg(ctrl1_r),
    .vbat_mv(battery_voltage_mv),
    .ichg_ma(charge_current_ma),
    .chg_en(charge_enable),
    .term_x10(term_current_x10),
    .prechg_x10(precharge_current_x10),
    .uv_mv(undervoltage_mv)
  );

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_ts_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ1
    ev_s[FLG_TS] |=> flags_r[FLG_TS]) else $error("thermistor flag not set");
  a_ilim_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ2
    ev_s[FLG_ILIM] |=> flags_r[FLG_ILIM]) else $error("input limit flag not set");
  a_dpm_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ3
    1'b1 |=> (flags_r[5:4] & $past(ev_s[5:4])) == $past(ev_s[5:4]))
    else $error("regulation flag not set");
  a_therm_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ4
    ev_s[FLG_THERM] |=> flags_r[FLG_THERM]) else $error("thermal flag not set");
  a_ovp_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ5
    ev_s[FLG_OVP] |=> flags_r[FLG_OVP]) else $error("overvoltage flag not set");
  a_uv_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ6
    ev_s[FLG_UV] |=> flags_r[FLG_UV]) else $error("undervoltage flag not set");
  a_ocp_latch: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ7
    ev_s[FLG_OCP] |=> flags_r[FLG_OCP]) else $error("overcurrent flag not set");
  a_flag_rdclr: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ21
    (ld_w && (ptr_r == OFS_FLAGS) && (ev_s == 8'h00)) |=>
    (flags_r == 8'h00) && (sh_r == $past(flags_r))) else $error("flag read-clear wrong");
  a_cs_irq: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ17
    ((cs_eff != charge_state_code) && !ctrl1_r[MASK_CS_BIT]) |=> status_irq)
    else $error("state change interrupt missing");
  a_ilim_irq: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ18
    (ev_s[FLG_ILIM] && !ev_d_r[FLG_ILIM] && !ctrl1_r[MASK_ILIM_BIT]) |=> status_irq)
    else $error("input limit interrupt missing");
  a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ19
    (ctrl1_r[2:0] == 3'h7) |=> !status_irq) else $error("masked interrupt raised");
  a_done_state: assert property (@(posedge core_clk) disable iff (!rst_b || !ce) // RQ20
    ichg_r[CHARGE_DISABLE_BIT] |=> charge_state_code == CS_DONE)
    else $error("disabled charge not reported done");
endmodule

// ---- bench/cfcr_host.sv ----
/*
  Host controller model for the two-wire register port.
  Assumes a pull-up on sda outside; scl is driven by this model alone.
*/
`timescale 1ns/10ps
module cfcr_host (
  // clock
  input wire logic core_clk,
  // bus
  input wire logic sda_in,
  output logic scl_o,
  output logic sda_pull
);
  import cfcr_pkg::*;
  initial
  begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // release first, so the same task also makes a repeated start
  task automatic start();
    sda_pull <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(5);
    sda_pull <= 1'b1;
    tick(5);
    scl_o <= 1'b0;
  endtask
  // sda moves one cycle after scl falls, never in the same cycle
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sda_pull <= !b;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    s = sda_in;
    scl_o <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(1'b1, s);
      d = {d[6:0], s};
    end
    bit_io(1'b1, s);
  endtask
  task automatic stop();
    tick(1);
    sda_pull <= 1'b1;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_pull <= 1'b0;
    tick(5);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({I2C_DEV_ADDR, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({I2C_DEV_ADDR, 1'b0}, a0);
    put_byte(ofs, a1);
    start();
    put_byte({I2C_DEV_ADDR, 1'b1}, a2);
    get_byte(d);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ---- bench/cfcr_bench.sv ----
/*
  Self-checking bench for the charger flag and setting registers.
  Assumes the host model drives the bus; ce is high except in the freeze test.
*/
`timescale 1ns/10ps
module charger_flag_and_charge_config_regs_bench;
  import cfcr_pkg::*;
  logic core_clk, rst_b, ce, scl, sda_pull, sda_oe, irq, chg_en;
  logic [7:0] ev;
  logic [1:0] cs_in, inreg, thsel, dlim;
  logic [12:0] vmv;
  logic [9:0] ima;
  logic [10:0] term;
  logic [11:0] pre, uv;
  cfcr_chg_state_t cs_code;
  int mismatches, comparisons;
  wire sda = !(sda_pull | sda_oe);
  cfcr_host host (.core_clk(core_clk), .sda_in(sda), .scl_o(scl), .sda_pull(sda_pull));
  cfcr_regs dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .thermistor_fault(ev[7]), .input_limit_active(ev[6]),
    .sys_power_regulation(ev[5]), .input_voltage_regulation(ev[4]),
    .thermal_regulation(ev[3]), .input_overvoltage(ev[2]), .battery_undervoltage(ev[1]),
    .battery_overcurrent(ev[0]), .charge_state_in(cs_in), .battery_voltage_mv(vmv),
    .charge_current_ma(ima), .charge_enable(chg_en), .term_current_x10(term),
    .precharge_current_x10(pre), .undervoltage_mv(uv), .input_regulation_level(inreg),
    .thermal_threshold_select(thsel), .discharge_limit_select(dlim),
    .charge_state_code(cs_code), .status_irq(irq));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    host.wr(ofs, d, ok);
    chk("write ack", 16'(ok), 16'h1);
  endtask
  task automatic rreg(input logic [7:0] ofs, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    host.rd(ofs, d, ok);
    chk("read ack", 16'(ok), 16'h1);
    chk("read data", 16'(d), 16'(exp));
  endtask
  // ------------------------------
  // hang guard
  // ------------------------------
  initial
  begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial
  begin
    logic [7:0] rv [6] = '{8'h00, 8'h46, 8'h05, 8'h2C, 8'h56, 8'h00};
    logic [7:0] vc [3] = '{8'h00, 8'h73, 8'h74};
    logic [15:0] ve [3] = '{16'd3500, 16'd4650, 16'd4650};
    logic [7:0] ic [5] = '{8'h00, 8'h1E, 8'h1F, 8'h20, 8'h7F};
    logic [15:0] ie [5] = '{16'd5, 16'd35, 16'd40, 16'd50, 16'd1000};
    logic [15:0] tt [4] = '{16'd0, 16'd500, 16'd1000, 16'd2000};
    int n;
    rst_b = 1'b0;
    ev = 8'h00;
    cs_in = 2'h0;
    ce = 1'b1;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("vbat mv", 16'(vmv), 16'd4200);
    chk("ichg ma", 16'(ima), 16'd10);
    chk("term", 16'(term), 16'd10);
    chk("prechg", 16'(pre), 16'd20);
    chk("uv mv", 16'(uv), 16'd3000);
    chk("fields", 16'({chg_en, inreg, thsel, dlim}), 16'h0071);
    for (int i = 0; i < 6; i++) rreg(8'(i + 2), rv[i]);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      ev <= 8'h01 << i;
      repeat (6) @(posedge core_clk);
      ev <= 8'h00;
      rreg(OFS_FLAGS, 8'h01 << i);
      rreg(OFS_FLAGS, 8'h00);
    end
    $display("test flags done");
    for (int i = 0; i < 3; i++)
    begin
      wreg(OFS_VBAT, vc[i]);
      chk("vbat mv", 16'(vmv), ve[i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      wreg(OFS_ICHG, ic[i]);
      chk("ichg ma", 16'(ima), ie[i]);
    end
    wreg(OFS_ICHG, 8'hFF);
    chk("disabled", 16'({chg_en, cs_code}), 16'h0003);
    wreg(OFS_ICHG, 8'h7F);
    $display("test targets done");
    for (int i = 0; i < 8; i++)
    begin
      wreg(OFS_CTRL0, {1'b0, i[0], i[2:1], 4'hC});
      chk("term", 16'(term), tt[i[2:1]]);
      chk("prechg", 16'(pre), i[0] ? tt[i[2:1]] : 16'(tt[i[2:1]] * 2));
    end
    for (int c = 0; c < 8; c++)
    begin
      wreg(OFS_CTRL1, {2'b10, c[2:0], 3'b111});
      chk("uv mv", 16'(uv), c < 3 ? 16'd3000 : 16'(3400 - 200 * c));
    end
    $display("test fields done");
    for (int k = 0; k < 4; k++)
      for (int m = 0; m < 2; m++)
      begin
        wreg(OFS_CTRL1, m ? 8'h57 : 8'h50);
        if (k == 0)
          cs_in <= cs_in + 2'h1;
        else
          ev[7 - k] <= 1'b1;
        n = 0;
        repeat (12)
        begin
          @(posedge core_clk);
          if (irq === 1'b1)
            n++;
        end
        chk("irq count", 16'(n), 16'(1 - m));
        chk("state", 16'(cs_code), 16'(cs_in));
        ev <= 8'h00;
        repeat (6) @(posedge core_clk);
      end
    $display("test irq done");
    // the irq scenarios left the limit and regulation flags latched
    rreg(OFS_FLAGS, 8'h70);
    // a pulse seen only while ce is low must leave no trace
    ce <= 1'b0;
    ev <= 8'h80;
    repeat (6) @(posedge core_clk);
    ev <= 8'h00;
    repeat (3) @(posedge core_clk);
    ce <= 1'b1;
    repeat (4) @(posedge core_clk);
    rreg(OFS_FLAGS, 8'h00);
    $display("test enable done");
    end_sim();
  end
endmodule
